/* core/cir_pkg.sv */
// Constants for the consumer infrared physical layer block
package cir_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_US = 64;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int CHAR_BITS = 10;
  localparam int CHAR_TIMES = 4;
  // ==========================================================
  // Fifo geometry
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [5:0] DEFER_LVL_16 = 6'h0E;
  localparam logic [5:0] DEFER_LVL_32 = 6'h1E;
  localparam logic [5:0] LVL_16 = 6'h10;
  // ==========================================================
  // Modulation modes
  localparam logic [1:0] MOD_CONT = 2'h0;
  localparam logic [1:0] MOD_SIX = 2'h1;
  localparam logic [1:0] MOD_EIGHT = 2'h2;
  localparam logic [3:0] SIX_PULSES = 4'h6;
  localparam logic [3:0] EIGHT_PULSES = 4'h8;
  // High speed carrier halves the carrier period
  localparam int HS_SHIFT = 1;
  // ==========================================================
  // Transmit states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_UNDER = 3'b100
  } tx_state_type;
endpackage : cir_pkg

/* core/consumer_ir_fifo_timeouts.sv */
// Consumer infrared transmit, receive, fifo time-outs and transmit deferral
`timescale 1ns/1ps
// Summary of operation
// - Transmission starts when bytes are written into an empty transmit fifo.
// - End-of-transmit flag or DMA terminal count ends transmission after last byte.
// - Draining empty without end raises underrun; must clear before next start.
// - Bytes serialize or run-length expand at baud rate, no start/stop/parity.
// - One bit keeps LED off; zero bit produces modulating pulses.
// - Carrier frequency and width follow modulation fields and high speed select.
// - Continuous mode pulses the carrier through every zero bit.
// - Six/eight pulse mode pulses only on zero after one, fewer if short.
// - Receiver activates at once without demodulation, else only in carrier band.
// - Entering active state sets the receiver active flag.
// - Active receiver samples at baud rate, packs bytes or run lengths to fifo.
// - Watchdog flag sets on each detected pulse, clears when status register is read.
// - Writing one to receiver active flag clears it and stops reception.
// - Demodulator band comes from centre frequency and bandwidth fields.
// - Programmed period mode resynchronises sampling on each new pulse.
// - Time-out raises data ready irq, extended DMA request, and status bit while level is below threshold.
// - Time-out stays set until the receive fifo is read.
// - Event A: data held, greater of 64 us and four chars since load and read.
// - Event B: same with the smaller interval, drives only the DMA request.
// - Remote mode time-out waits 64 us after byte, inactivity and last read.
// - Deferral locks an empty transmitter until level reaches 14 or 30.
// - Deferral timer reloads per write; 64 us quiet clears the lock.
module consumer_ir_fifo_timeouts
  import cir_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic baud_tick,
  input wire logic remote_mode,
  input wire logic extended_mode,
  input wire logic fifo_enable,
  input wire logic fifo_32,
  input wire logic run_length_mode,
  input wire logic programmed_period_mode,
  input wire logic demod_enable,
  input wire logic [4:0] carrier_frequency_field,
  input wire logic [3:0] carrier_pulse_width_field,
  input wire logic high_speed_carrier_select,
  input wire logic [1:0] modulation_mode_field,
  input wire logic [4:0] demod_center_frequency,
  input wire logic [2:0] demod_bandwidth,
  input wire logic rx_data_irq_enable,
  input wire logic rx_dma_enable,
  input wire logic transmit_deferral_enable,
  input wire logic [5:0] rx_threshold,
  input wire logic tx_wr,
  input wire logic [7:0] tx_wdata,
  input wire logic set_end_of_transmit,
  input wire logic dma_terminal_count,
  input wire logic underrun_clear,
  input wire logic aux_status_read,
  input wire logic rx_active_clear_wr,
  input wire logic rx_rd,
  input wire logic ir_rx_in,
  output logic tx_ready,
  output logic ir_led,
  output logic tx_busy,
  output logic tx_underrun,
  output logic receiver_active_flag,
  output logic receive_watchdog_flag,
  output logic receive_timeout_flag,
  output logic rx_data_irq,
  output logic rx_dma_req,
  output logic rx_valid,
  output logic [7:0] rx_rdata,
  output logic [5:0] rx_level
);
  // ==========================================================
  // Transmit fifo
  logic [7:0] txq [FIFO_DEPTH];
  logic [FIFO_AW-1:0] txw_ff, txr_ff;
  logic [5:0] txl_ff;
  logic [5:0] cap;
  logic tx_pop, tx_push;
  assign cap = fifo_32 ? 6'h20 : LVL_16;
  assign tx_ready = txl_ff < cap;
  assign tx_push = tx_wr && tx_ready;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txw_ff <= '0;
      txr_ff <= '0;
      txl_ff <= '0;
    end else begin
      if (tx_push) begin
        txw_ff <= txw_ff + 1'b1;
      end
      if (tx_pop) begin
        txr_ff <= txr_ff + 1'b1;
      end
      txl_ff <= 6'(txl_ff + {5'h0, tx_push} - {5'h0, tx_pop});
    end
  end
  generate
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_txq
      always_ff @(posedge core_clk) begin
        if (tx_push && txw_ff == FIFO_AW'(i)) begin
          txq[i] <= tx_wdata;
        end
      end
    end
  endgenerate
  // ==========================================================
  // Deferral lock
  logic lock_ff;
  logic [13:0] dfr_ff;
  logic defer_on;
  assign defer_on = transmit_deferral_enable && extended_mode && fifo_enable;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
      dfr_ff <= '0;
    end else begin
      if (tx_push || !lock_ff || txl_ff == 6'h0) begin
        dfr_ff <= '0;
      end else begin
        dfr_ff <= dfr_ff + 1'b1;
      end
      if (defer_on && txl_ff == 6'h0 && !tx_busy) begin
        lock_ff <= 1'b1;
      end else if (txl_ff >= (fifo_32 ? DEFER_LVL_32 : DEFER_LVL_16)) begin
        lock_ff <= 1'b0;
      end else if (32'(dfr_ff) >= TIMEOUT_CYC - 1) begin
        lock_ff <= 1'b0;
      end else if (!defer_on) begin
        lock_ff <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Transmit sequencer
  tx_state_type tx_st_ff;
  logic [7:0] sh_ff;
  logic [3:0] bcnt_ff;
  logic last_ff, eot_pend_ff, txbit_ff, prev_bit_ff;
  logic need_byte;
  assign tx_busy = tx_st_ff == TX_SEND;
  assign tx_underrun = tx_st_ff == TX_UNDER;
  assign need_byte = baud_tick && bcnt_ff == 4'h0;
  assign tx_pop = tx_busy && need_byte && !last_ff && txl_ff != 6'h0 && !lock_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff <= TX_IDLE;
      sh_ff <= '0;
      bcnt_ff <= '0;
      last_ff <= 1'b0;
      eot_pend_ff <= 1'b0;
      txbit_ff <= 1'b1;
      prev_bit_ff <= 1'b1;
    end else begin
      if (set_end_of_transmit) begin
        eot_pend_ff <= 1'b1;
      end
      case (tx_st_ff)
        TX_IDLE: begin
          txbit_ff <= 1'b1;
          if (txl_ff != 6'h0 && !lock_ff) begin
            tx_st_ff <= TX_SEND;
            bcnt_ff <= '0;
            last_ff <= 1'b0;
          end
        end
        TX_SEND: begin
          if (baud_tick) begin
            prev_bit_ff <= txbit_ff;
            if (bcnt_ff != 4'h0) begin
              // plain bits, run length counts down
              txbit_ff <= run_length_mode ? sh_ff[7] : sh_ff[0];
              sh_ff <= run_length_mode ? sh_ff : {1'b1, sh_ff[7:1]};
              bcnt_ff <= bcnt_ff - 1'b1;
            end else if (tx_pop) begin
              // run length: bit 7 level, low bits count plus one
              txbit_ff <= run_length_mode ? txq[txr_ff][7] : txq[txr_ff][0];
              sh_ff <= run_length_mode ? txq[txr_ff] : {1'b1, txq[txr_ff][7:1]};
              bcnt_ff <= run_length_mode ? {1'b0, txq[txr_ff][2:0]} : 4'h7;
              // end flag or terminal count marks last byte
              if (eot_pend_ff || dma_terminal_count) begin
                last_ff <= 1'b1;
                eot_pend_ff <= set_end_of_transmit;
              end
            end else if (last_ff) begin
              tx_st_ff <= TX_IDLE;
              txbit_ff <= 1'b1;
            end else if (!lock_ff) begin
              tx_st_ff <= TX_UNDER;
              txbit_ff <= 1'b1;
            end
          end
        end
        TX_UNDER: begin
          txbit_ff <= 1'b1;
          if (underrun_clear) begin
            tx_st_ff <= TX_IDLE;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Carrier generator
  logic [7:0] car_ff;
  logic [7:0] per;
  logic [3:0] npulse_ff;
  logic led_ff;
  // period from frequency field, halved at high speed
  assign per = high_speed_carrier_select ? 8'({3'h0, carrier_frequency_field} + 8'h4) >> HS_SHIFT
                                         : 8'({3'h0, carrier_frequency_field} + 8'h4);
  assign ir_led = led_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      car_ff <= '0;
      npulse_ff <= '0;
      led_ff <= 1'b0;
    end else begin
      if (txbit_ff || !tx_busy) begin
        car_ff <= '0;
        led_ff <= 1'b0;
        npulse_ff <= '0;
      end else begin
        car_ff <= (car_ff >= per - 8'h1) ? 8'h0 : car_ff + 1'b1;
        if (car_ff == per - 8'h1 && npulse_ff != 4'hF) begin
          npulse_ff <= npulse_ff + 1'b1;
        end
        if (modulation_mode_field == MOD_CONT) begin
          led_ff <= car_ff < {4'h0, carrier_pulse_width_field};
        // counted pulses after a one, cut short with the bit
        end else begin
          led_ff <= car_ff < {4'h0, carrier_pulse_width_field} &&
                    npulse_ff < (modulation_mode_field == MOD_SIX ? SIX_PULSES : EIGHT_PULSES);
        end
      end
      if (baud_tick && !txbit_ff && !prev_bit_ff) begin
        npulse_ff <= 4'hF;
      end
    end
  end
  // ==========================================================
  // Receive input, demodulator and activity
  logic rs1_ff, rs2_ff, rs3_ff;
  logic [7:0] gap_ff;
  logic in_band, pulse_edge;
  logic [7:0] lo, hi;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_ff <= 1'b1;
      rs2_ff <= 1'b1;
      rs3_ff <= 1'b1;
    end else begin
      rs1_ff <= ir_rx_in;
      rs2_ff <= rs1_ff;
      rs3_ff <= rs2_ff;
    end
  end
  // Input is active low: low means infrared energy
  assign pulse_edge = rs3_ff && !rs2_ff;
  // band from centre and bandwidth fields
  assign lo = 8'({3'h0, demod_center_frequency} + 8'h4) - {5'h0, demod_bandwidth};
  assign hi = 8'({3'h0, demod_center_frequency} + 8'h4) + {5'h0, demod_bandwidth};
  assign in_band = gap_ff >= lo && gap_ff <= hi;
  logic energy_ff;
  logic [7:0] hold_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= '0;
      hold_ff <= '0;
      energy_ff <= 1'b0;
    end else begin
      gap_ff <= pulse_edge ? 8'h1 : (gap_ff == 8'hFF ? gap_ff : gap_ff + 1'b1);
      // Demodulated energy persists for twice the upper band period (hi) after an in-band edge
      if (pulse_edge && in_band) begin
        hold_ff <= 8'(hi << 1);
      end else if (hold_ff != 8'h0) begin
        hold_ff <= hold_ff - 1'b1;
      end
      energy_ff <= demod_enable ? (hold_ff != 8'h0) : !rs2_ff;
    end
  end
  logic detect;
  assign detect = pulse_edge && (!demod_enable || in_band);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_active_flag <= 1'b0;
      receive_watchdog_flag <= 1'b0;
    end else begin
      if (detect) begin
        receiver_active_flag <= 1'b1;
      // software write of one stops reception
      end else if (rx_active_clear_wr) begin
        receiver_active_flag <= 1'b0;
      end
      if (detect) begin
        receive_watchdog_flag <= 1'b1;
      end else if (aux_status_read) begin
        receive_watchdog_flag <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Sampler and packer
  logic [7:0] pk_ff;
  logic [3:0] pn_ff;
  logic rx_push;
  logic [7:0] rx_pdata;
  logic samp;
  // resync phase on new pulse in programmed period mode
  assign samp = programmed_period_mode ? (pulse_edge || baud_tick) : baud_tick;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_ff <= '0;
      pn_ff <= '0;
      rx_push <= 1'b0;
      rx_pdata <= '0;
    end else begin
      rx_push <= 1'b0;
      if (receiver_active_flag && samp) begin
        if (run_length_mode) begin
          if (pn_ff != 4'h0 && (pk_ff[7] != !energy_ff || pk_ff[6:0] == 7'h7F)) begin
            rx_push <= 1'b1;
            rx_pdata <= pk_ff;
            pk_ff <= {!energy_ff, 7'h0};
          end else begin
            pk_ff <= {!energy_ff, 7'(pk_ff[6:0] + (pn_ff != 4'h0 ? 7'h1 : 7'h0))};
          end
          pn_ff <= 4'h1;
        end else if (pn_ff == 4'h7) begin
          rx_push <= 1'b1;
          rx_pdata <= {!energy_ff, pk_ff[7:1]};
          pn_ff <= '0;
        end else begin
          pk_ff <= {!energy_ff, pk_ff[7:1]};
          pn_ff <= pn_ff + 1'b1;
        end
      end
      if (!receiver_active_flag) begin
        pn_ff <= '0;
      end
    end
  end
  // ==========================================================
  // Receive fifo
  logic [7:0] rxq [FIFO_DEPTH];
  logic [FIFO_AW-1:0] rxw_ff, rxr_ff;
  logic [5:0] rxl_ff;
  logic do_push, do_pop;
  assign do_push = rx_push && rxl_ff < cap;
  assign do_pop = rx_rd && rxl_ff != 6'h0;
  assign rx_level = rxl_ff;
  assign rx_valid = rxl_ff != 6'h0;
  assign rx_rdata = rxq[rxr_ff];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxw_ff <= '0;
      rxr_ff <= '0;
      rxl_ff <= '0;
    end else begin
      if (do_push) begin
        rxw_ff <= rxw_ff + 1'b1;
      end
      if (do_pop) begin
        rxr_ff <= rxr_ff + 1'b1;
      end
      rxl_ff <= 6'(rxl_ff + {5'h0, do_push} - {5'h0, do_pop});
    end
  end
  generate
    for (genvar j = 0; j < FIFO_DEPTH; j++) begin : g_rxq
      always_ff @(posedge core_clk) begin
        if (do_push && rxw_ff == FIFO_AW'(j)) begin
          rxq[j] <= rx_pdata;
        end
      end
    end
  endgenerate
  // ==========================================================
  // Time-outs
  logic [19:0] since_ld_ff, since_rd_ff, since_act_ff, char4;
  logic [19:0] t_big, t_small;
  logic [15:0] baud_period_ff, baud_cnt_ff;
  logic tout_a_ff, tout_b_ff;
  // Four ten-bit characters, in clocks measured between baud ticks
  assign char4 = 20'(CHAR_TIMES * CHAR_BITS) * 20'(baud_period_ff);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_ff <= '0;
      baud_period_ff <= 16'h0001;
    end else if (baud_tick) begin
      baud_cnt_ff <= '0;
      baud_period_ff <= baud_cnt_ff + 1'b1;
    end else if (baud_cnt_ff != 16'hFFFF) begin
      baud_cnt_ff <= baud_cnt_ff + 1'b1;
    end
  end
  assign t_big = (char4 > 20'(TIMEOUT_CYC)) ? char4 : 20'(TIMEOUT_CYC);
  assign t_small = (char4 < 20'(TIMEOUT_CYC)) ? char4 : 20'(TIMEOUT_CYC);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ld_ff <= '0;
      since_rd_ff <= '0;
      since_act_ff <= '0;
    end else begin
      since_ld_ff <= do_push ? 20'h0 : (&since_ld_ff ? since_ld_ff : since_ld_ff + 1'b1);
      since_rd_ff <= do_pop ? 20'h0 : (&since_rd_ff ? since_rd_ff : since_rd_ff + 1'b1);
      since_act_ff <= receiver_active_flag ? 20'h0
                    : (&since_act_ff ? since_act_ff : since_act_ff + 1'b1);
    end
  end
  logic cond_a, cond_b, cond_rc;
  assign cond_a = rx_valid && since_ld_ff > t_big && since_rd_ff > t_big;
  assign cond_b = rx_valid && since_ld_ff > t_small && since_rd_ff > t_small;
  assign cond_rc = rx_valid && !receiver_active_flag && since_ld_ff >= 20'(TIMEOUT_CYC) &&
                   since_act_ff >= 20'(TIMEOUT_CYC) && since_rd_ff > 20'(TIMEOUT_CYC);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tout_a_ff <= 1'b0;
      tout_b_ff <= 1'b0;
      receive_timeout_flag <= 1'b0;
    end else begin
      // held until the fifo is read; a new event still wins
      if (remote_mode ? cond_rc : cond_a) begin
        tout_a_ff <= 1'b1;
        if (rxl_ff < rx_threshold) begin
          receive_timeout_flag <= 1'b1;
        end
      end else if (do_pop) begin
        tout_a_ff <= 1'b0;
        receive_timeout_flag <= 1'b0;
      end
      if (!remote_mode && cond_b) begin
        tout_b_ff <= 1'b1;
      end else if (do_pop) begin
        tout_b_ff <= 1'b0;
      end
    end
  end
  assign rx_data_irq = rx_data_irq_enable && (tout_a_ff || rxl_ff >= rx_threshold);
  assign rx_dma_req = rx_dma_enable && extended_mode &&
                      (tout_a_ff || tout_b_ff || rxl_ff >= rx_threshold);
endmodule : consumer_ir_fifo_timeouts

/* testbench/cir_checker_properties.sv */
// Port assertions for the consumer infrared block
`timescale 1ns/1ps
module cir_checker
  import cir_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic underrun_clear,
  input wire logic aux_status_read,
  input wire logic rx_active_clear_wr,
  input wire logic rx_rd,
  input wire logic ir_rx_in,
  input wire logic rx_data_irq_enable,
  input wire logic rx_dma_enable,
  input wire logic ir_led,
  input wire logic tx_busy,
  input wire logic tx_underrun,
  input wire logic receiver_active_flag,
  input wire logic receive_watchdog_flag,
  input wire logic receive_timeout_flag,
  input wire logic rx_data_irq,
  input wire logic rx_dma_req,
  input wire logic rx_valid
);
  int rd_quiet_ff;
  int idle_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ======================================
  // Saturating helper counters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_quiet_ff <= 0;
    end else if (rx_rd && rx_valid) begin
      rd_quiet_ff <= 0;
    end else if (rd_quiet_ff < TIMEOUT_CYC) begin
      rd_quiet_ff <= rd_quiet_ff + 1;
    end
  end
  // Idle time of the infrared input
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ff <= 0;
    end else if (!ir_rx_in) begin
      idle_ff <= 0;
    end else if (idle_ff < 31) begin
      idle_ff <= idle_ff + 1;
    end
  end
  // ======================================
  // Assertions
  a_led_idle: assert property (!tx_busy ##1 !tx_busy |-> !ir_led)
    else $error("led lit while transmitter idle");
  a_underrun_holds: assert property (tx_underrun && !underrun_clear |=> tx_underrun)
    else $error("underrun dropped without clear");
  a_underrun_blocks: assert property (tx_underrun && !underrun_clear |=> !tx_busy)
    else $error("transmit started during underrun");
  a_wdg_sticky: assert property (receive_watchdog_flag && !aux_status_read &&
    !rx_active_clear_wr |=> receive_watchdog_flag) else $error("watchdog flag lost");
  a_wdg_clear: assert property (aux_status_read && idle_ff > 12 |=>
    !receive_watchdog_flag) else $error("watchdog flag not cleared by status read");
  a_receiver_active_flag_clear: assert property (rx_active_clear_wr && idle_ff > 12 |=>
    !receiver_active_flag) else $error("receiver stayed active after clear");
  a_tmo_sticky: assert property (receive_timeout_flag && !rx_rd |=> receive_timeout_flag)
    else $error("time-out dropped without read");
  a_tmo_read_gap: assert property ($rose(receive_timeout_flag) |->
    rd_quiet_ff >= TIMEOUT_CYC - 2) else $error("time-out too soon after read");
  a_irq_gate: assert property (receive_timeout_flag && rx_data_irq_enable |->
    rx_data_irq) else $error("time-out without data ready irq");
  a_dma_gate: assert property (rx_dma_req |-> rx_dma_enable)
    else $error("dma request while disabled");
  c_underrun: cover property ($rose(tx_underrun));
  c_timeout: cover property ($rose(receive_timeout_flag));
  c_rx_active: cover property ($rose(receiver_active_flag));
endmodule : cir_checker

/* testbench/consumer_ir_fifo_timeouts_tb_top.sv */
// Self-checking bench for the consumer infrared block
`timescale 1ns/1ps
module consumer_ir_fifo_timeouts_tb_top
  import cir_pkg::*;
;
  typedef struct {
    logic [1:0] mode;
    logic hs;
    logic [4:0] cf;
    logic [7:0] data;
    int pulses;
  } row_type;
  // Bit time 96 clocks; carrier period is field plus 4, halved at high speed
  row_type rows [6] = '{
    '{MOD_CONT, 1'b0, 5'h04, 8'hFE, 12}, '{MOD_CONT, 1'b0, 5'h04, 8'hFC, 24},
    '{MOD_CONT, 1'b1, 5'h04, 8'hFE, 24}, '{MOD_SIX, 1'b0, 5'h04, 8'hFC, 6},
    '{MOD_EIGHT, 1'b0, 5'h04, 8'hF6, 16}, '{MOD_EIGHT, 1'b0, 5'h0C, 8'hFE, 6}};
  logic core_clk, rst_n, baud_tick, remote_mode, extended_mode, fifo_enable, fifo_32;
  logic run_length_mode, programmed_period_mode, demod_enable, high_speed_carrier_select;
  logic [4:0] carrier_frequency_field, demod_center_frequency;
  logic [3:0] carrier_pulse_width_field;
  logic [1:0] modulation_mode_field;
  logic [2:0] demod_bandwidth;
  logic rx_data_irq_enable, rx_dma_enable, transmit_deferral_enable, tx_wr, set_end_of_transmit;
  logic [5:0] rx_threshold, rx_level;
  logic [7:0] tx_wdata, rx_rdata;
  logic dma_terminal_count, underrun_clear, aux_status_read, rx_active_clear_wr, rx_rd, ir_rx_in;
  logic tx_ready, ir_led, tx_busy, tx_underrun, receiver_active_flag, receive_watchdog_flag;
  logic receive_timeout_flag, rx_data_irq, rx_dma_req, rx_valid;
  int n_errors = 0;
  int n_checks = 0;
  int led_pulses;
  int baud_cnt = 0;

  consumer_ir_fifo_timeouts dut_u (.*);
  ir_xcvr_model xcvr_u (.core_clk, .ir_led, .ir_rx_in, .led_pulses);

  // ======================================
  // Clock, baud ticks and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    baud_cnt <= (baud_cnt == 95) ? 0 : baud_cnt + 1;
    baud_tick <= (baud_cnt == 95);
  end
  // Tests need about 40000 cycles; this cuts a hang at 87500
  initial begin
    #700000;
    n_errors++;
    complete_run();
  end

  // ======================================
  // Tasks
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  // End flag goes one cycle ahead of the byte it closes
  task automatic send(input logic [7:0] b, input logic eot);
    @(posedge core_clk) set_end_of_transmit <= eot;
    @(posedge core_clk) set_end_of_transmit <= 1'b0;
    tx_wr <= 1'b1;
    tx_wdata <= b;
    @(posedge core_clk) tx_wr <= 1'b0;
  endtask : send
  task automatic run_tx(input int rise_lim, input int fall_lim);
    int i;
    for (i = 0; i < rise_lim && tx_busy !== 1'b1; i++) @(negedge core_clk);
    chk(tx_busy === 1'b1, "transmit did not start");
    for (i = 0; i < fall_lim && tx_busy !== 1'b0; i++) @(negedge core_clk);
    chk(tx_busy === 1'b0, "transmit did not finish");
    repeat (2) @(negedge core_clk);
  endtask : run_tx
  task automatic clr_under();
    @(posedge core_clk) underrun_clear <= 1'b1;
    @(posedge core_clk) underrun_clear <= 1'b0;
  endtask : clr_under
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ======================================
  // Main sequence
  initial begin
    int p0;
    int i;
    logic [7:0] last_b;
    rst_n = 1'b0;
    {remote_mode, extended_mode, fifo_enable, fifo_32, run_length_mode, programmed_period_mode,
     demod_enable, high_speed_carrier_select, rx_data_irq_enable, rx_dma_enable} = '0;
    {transmit_deferral_enable, tx_wr, set_end_of_transmit, dma_terminal_count, underrun_clear,
     aux_status_read, rx_active_clear_wr, rx_rd, modulation_mode_field, demod_bandwidth} = '0;
    {carrier_frequency_field, demod_center_frequency, tx_wdata} = '0;
    carrier_pulse_width_field = 4'h2;
    rx_threshold = 6'h20;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk({ir_led, tx_busy, tx_underrun, receiver_active_flag, receive_watchdog_flag,
      receive_timeout_flag, rx_data_irq, rx_dma_req, rx_valid, rx_level} === '0, "reset state");
    foreach (rows[k]) begin
      @(posedge core_clk);
      modulation_mode_field <= rows[k].mode;
      high_speed_carrier_select <= rows[k].hs;
      carrier_frequency_field <= rows[k].cf;
      p0 = led_pulses;
      send(rows[k].data, 1'b1);
      run_tx(8, 1200);
      chk(led_pulses - p0 == rows[k].pulses, "carrier pulse count");
      chk(tx_underrun === 1'b0, "end flag left underrun");
    end
    send(8'hFF, 1'b0);
    run_tx(8, 1200);
    chk(tx_underrun === 1'b1, "drained without underrun");
    send(8'hFE, 1'b1);
    repeat (300) @(negedge core_clk);
    chk(tx_busy === 1'b0, "started during underrun");
    clr_under();
    run_tx(8, 1200);
    chk(tx_underrun === 1'b0, "underrun not cleared");
    // Deferral: one short of the level, the level, then the quiet timer
    @(posedge core_clk) extended_mode <= 1'b1;
    fifo_enable <= 1'b1;
    transmit_deferral_enable <= 1'b1;
    repeat (DEFER_LVL_16 - 1) send(8'hFF, 1'b0);
    repeat (20) @(negedge core_clk);
    chk(tx_busy === 1'b0 && tx_ready === 1'b1, "sent below deferral level");
    send(8'hFF, 1'b0);
    run_tx(8, 11000);
    clr_under();
    send(8'hFF, 1'b0);
    repeat (7900) @(negedge core_clk);
    chk(tx_busy === 1'b0, "deferral released early");
    run_tx(400, 1200);
    clr_under();
    @(posedge core_clk) transmit_deferral_enable <= 1'b0;
    remote_mode <= 1'b1;
    demod_enable <= 1'b1;
    demod_center_frequency <= 5'h04;
    demod_bandwidth <= 3'h1;
    rx_data_irq_enable <= 1'b1;
    rx_dma_enable <= 1'b1;
    xcvr_u.burst(40, 10);
    @(negedge core_clk);
    chk(receiver_active_flag === 1'b0, "out of band carrier accepted");
    xcvr_u.burst(8, 50);
    @(negedge core_clk);
    chk(receiver_active_flag === 1'b1, "in band carrier ignored");
    chk(receive_watchdog_flag === 1'b1, "pulse not flagged");
    repeat (3000) @(negedge core_clk);
    chk(rx_valid === 1'b1, "no samples packed");
    @(posedge core_clk) aux_status_read <= 1'b1;
    @(posedge core_clk) aux_status_read <= 1'b0;
    @(negedge core_clk);
    chk(receive_watchdog_flag === 1'b0, "watchdog kept after read");
    @(posedge core_clk) rx_active_clear_wr <= 1'b1;
    @(posedge core_clk) rx_active_clear_wr <= 1'b0;
    @(negedge core_clk);
    chk(receiver_active_flag === 1'b0, "receiver not stopped");
    repeat (7800) @(negedge core_clk);
    chk(receive_timeout_flag === 1'b0, "time-out too early");
    for (i = 0; i < 600 && receive_timeout_flag !== 1'b1; i++) @(negedge core_clk);
    chk(receive_timeout_flag === 1'b1, "time-out missing");
    chk(rx_data_irq === 1'b1, "no data ready irq");
    chk(rx_dma_req === 1'b1, "no dma request");
    repeat (50) @(negedge core_clk);
    chk(receive_timeout_flag === 1'b1, "time-out dropped unread");
    for (i = 0; i < 40 && rx_valid === 1'b1; i++) begin
      last_b = rx_rdata;
      @(posedge core_clk) rx_rd <= 1'b1;
      @(posedge core_clk) rx_rd <= 1'b0;
      @(negedge core_clk);
    end
    chk(receive_timeout_flag === 1'b0, "time-out kept after read");
    chk(last_b === 8'hFF, "idle samples not ones");
    complete_run();
  end
endmodule : consumer_ir_fifo_timeouts_tb_top

bind consumer_ir_fifo_timeouts cir_checker chk_u (.*);

/* testbench/ir_xcvr_model.sv */
// Behavioural optical transceiver: counts LED pulses, sends infrared bursts
`timescale 1ns/1ps
module ir_xcvr_model (
  input wire logic core_clk,
  input wire logic ir_led,
  output logic ir_rx_in,
  output int led_pulses
);
  logic led_q;
  // Receiver output idles high through its pull-up
  initial begin
    ir_rx_in = 1'b1;
    led_pulses = 0;
    led_q = 1'b0;
  end
  always @(posedge core_clk) begin
    led_q <= ir_led;
    if (ir_led && !led_q) begin
      led_pulses <= led_pulses + 1;
    end
  end
  // Carrier burst, low half of each period means infrared energy
  task automatic burst(input int period, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge core_clk) ir_rx_in <= 1'b0;
      repeat (period / 2) @(posedge core_clk);
      ir_rx_in <= 1'b1;
      repeat (period - period / 2 - 1) @(posedge core_clk);
    end
  endtask : burst
endmodule : ir_xcvr_model
